/* bench/pause_user_model.sv */
// user-side pause processing model: acknowledges requests, keeps the quanta seen
// assumes the device outputs are registered on clk
`timescale 1ns/1ps
module pause_user_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // device side
  input wire logic [8:0] req,
  input wire logic [8:0] valid,
  input wire rx_pause_pkg::quanta_arr_t quanta,
  output logic [8:0] ack,
  // bench controls
  input wire logic hold,
  input wire logic [1:0] dly,
  input wire logic clr,
  output logic [8:0] seen_valid,
  output rx_pause_pkg::quanta_arr_t seen_quanta
);
  import rx_pause_pkg::*;
  logic [8:0][1:0] age_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      age_ff <= '0;
      seen_valid <= '0;
      seen_quanta <= '0;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        age_ff[i] <= !req[i] ? 2'h0 : (age_ff[i] == 2'h3 ? 2'h3 : age_ff[i] + 2'h1);
        if (valid[i]) seen_quanta[i] <= quanta[i];
      end
      seen_valid <= clr ? 9'h000 : (seen_valid | valid);
    end
  end
  // hold models a slow user that leaves a request pending
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) ack[i] = req[i] && !hold && (age_ff[i] >= dly);
  end
endmodule

/* bench/tb_rx_priority_pause_interface.sv */
// self-checking bench for the receive pause interface
// assumes the partner model answers every request unless held
`timescale 1ns/1ps
module tb_rx_priority_pause_interface;
  import rx_pause_pkg::*;
  logic CLK = 0, RESET_N = 0, WR = 0, RD = 0, IRQ;
  logic [7:0] ADDR = 0, RX_DATA = 0;
  logic [31:0] WDATA = 0, RDATA, s = 32'hb4fa_99c8;
  logic RX_VALID = 0, RX_SOP = 0, RX_EOP = 0, RX_ERR = 0, hold = 0, clr = 0;
  logic [1:0] dly = 0;
  logic [8:0] req, vld, ack, vmask, ctl = 9'h131, pe = 9'h1ff;
  quanta_arr_t qa, got_q;
  logic [47:0] stn = 48'h0012_3456_789a, sa0 = 48'h0002_0000_0001;
  int err_count = 0, n_tests = 0, cyc = 0;

  rx_priority_pause_interface dut_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_SOP(RX_SOP), .RX_EOP(RX_EOP),
    .RX_ERR(RX_ERR), .RX_PAUSE_REQ(req), .RX_PAUSE_VALID(vld), .RX_PAUSE_QUANTA(qa),
    .RX_PAUSE_ACKNOWLEDGE(ack), .IRQ(IRQ));
  pause_user_model user_u (.clk(CLK), .reset_n(RESET_N), .req(req), .valid(vld), .quanta(qa), .ack(ack),
    .hold(hold), .dly(dly), .clr(clr), .seen_valid(vmask), .seen_quanta(got_q));

  initial begin
    forever #2.5 CLK = ~CLK;
  end

  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // slot mask expected from the control state and the frame fields
  function automatic logic [8:0] exp_mask(logic [47:0] da, sa, logic [15:0] et, op, cev, logic good);
    logic da_ok, p_ok, g_ok;
    da_ok = (!ctl[1] && !ctl[2]) || (ctl[1] && da == PAUSE_MCAST_DA) || (ctl[2] && da == stn);
    p_ok = good && ctl[0] && !(et == PAUSE_ETHERTYPE && op == OPCODE_GLOBAL) && da_ok &&
      (!ctl[3] || !sa[ADDR_GROUP_BIT]) && (!ctl[4] || et == PAUSE_ETHERTYPE) && (!ctl[5] || op == OPCODE_PRIO);
    g_ok = good && ctl[8] && et == PAUSE_ETHERTYPE && op == OPCODE_GLOBAL && (da == PAUSE_MCAST_DA || da == stn);
    return {g_ok, cev[7:0] & {8{p_ok}}} & pe;
  endfunction

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 0;
    #1 d = RDATA;
  endtask

  task automatic irq_is(logic e);
    repeat (2) @(posedge CLK);
    #1 chk("irq", IRQ, e);
  endtask

  task automatic frame(logic [47:0] da, sa, logic [15:0] et, op, cev, logic err, output logic [8:0] m);
    logic [271:0] f;
    logic [15:0] qv [8];
    for (int i = 0; i < 8; i++) qv[i] = 16'(rnd());
    f = {da, sa, et, op, cev, 128'h0};
    for (int i = 0; i < 8; i++) f[127-16*i -: 16] = qv[i];
    m = exp_mask(da, sa, et, op, cev, !err);
    @(posedge CLK) clr <= 1;
    @(posedge CLK) clr <= 0;
    for (int k = 0; k < HDR_BYTES; k++) begin
      @(posedge CLK);
      RX_VALID <= 1;
      RX_DATA <= f[271-8*k -: 8];
      RX_SOP <= (k == 0);
      RX_EOP <= (k == HDR_BYTES - 1);
      RX_ERR <= err && (k == HDR_BYTES - 1);
    end
    @(posedge CLK);
    RX_VALID <= 0;
    RX_EOP <= 0;
    RX_ERR <= 0;
    repeat (6) @(posedge CLK);
    #1 chk("valid", vmask, m);
    for (int i = 0; i < NUM_PRIO; i++) if (m[i]) chk("quanta", got_q[i], qv[i]);
    if (m[GLOBAL_SLOT]) chk("quanta8", got_q[GLOBAL_SLOT], cev);
    if (!hold) chk("req", req, 0);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // frames take about 45 cycles; the ceiling leaves wide margin
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] d;
    logic [8:0] m;
    logic [47:0] da;
    logic [15:0] et, op;
    repeat (5) @(posedge CLK);
    RESET_N <= 1;
    rd(ADDR_CTRL, d);
    chk("ctrl", d, 32'h0000_0131);
    rd(ADDR_PRIO_EN, d);
    chk("prio_en", d, 32'h0000_01ff);
    rd(8'h30, d);
    chk("unmapped", d, 32'h0000_0000);
    wr(ADDR_STN_LO, stn[31:0]);
    wr(ADDR_STN_HI, {16'h0000, stn[47:32]});
    wr(ADDR_INT_EN, 32'h0000_0001);
    frame(PAUSE_MCAST_DA, sa0, PAUSE_ETHERTYPE, OPCODE_PRIO, 16'h00a5, 0, m);
    chk("irq_set", IRQ, 1);
    rd(ADDR_STATUS, d);
    chk("status", d[0], 1);
    rd(ADDR_CNT_PRIO, d);
    chk("cnt_prio", d, 32'h0000_0001);
    wr(ADDR_INT_EN, 32'h0000_0000);
    irq_is(0);
    wr(ADDR_INT_EN, 32'h0000_0001);
    irq_is(1);
    wr(ADDR_INT_CLR, 32'h0000_0001);
    irq_is(0);
    // request must stand while the user withholds acknowledge
    hold <= 1;
    frame(stn, sa0, PAUSE_ETHERTYPE, OPCODE_PRIO, 16'h0081, 0, m);
    repeat (20) @(posedge CLK);
    rd(ADDR_REQ_STATE, d);
    chk("req_state", d, {23'h0, m});
    chk("req_held", req, m);
    hold <= 0;
    repeat (4) @(posedge CLK);
    #1 chk("req_drop", req, 0);
    frame(PAUSE_MCAST_DA, sa0, PAUSE_ETHERTYPE, OPCODE_GLOBAL, 16'hbeef, 0, m);
    chk("global_slot", vmask, 9'h100);
    frame(PAUSE_MCAST_DA, sa0, PAUSE_ETHERTYPE, OPCODE_PRIO, 16'h00ff, 1, m);
    rd(ADDR_CNT_GLOB, d);
    chk("cnt_glob", d, 32'h0000_0001);
    rd(ADDR_CNT_REJ, d);
    chk("cnt_rej", d, 32'h0000_0001);
    // slot enables off: user sees nothing, the frame is still counted
    pe = 9'h000;
    wr(ADDR_PRIO_EN, 32'h0000_0000);
    frame(PAUSE_MCAST_DA, sa0, PAUSE_ETHERTYPE, OPCODE_PRIO, 16'h00ff, 0, m);
    rd(ADDR_CNT_PRIO, d);
    chk("cnt_prio_masked", d, 32'h0000_0003);
    for (int n = 0; n < 60; n++) begin
      ctl = 9'(rnd()) & 9'h13f;
      pe = 9'(rnd());
      wr(ADDR_CTRL, {23'h0, ctl});
      wr(ADDR_PRIO_EN, {23'h0, pe});
      dly <= 2'(rnd());
      case (rnd() % 3)
        0: da = PAUSE_MCAST_DA;
        1: da = stn;
        default: da = 48'({rnd(), rnd()}) & ~(48'h1 << ADDR_GROUP_BIT);
      endcase
      et = rnd() % 4 == 0 ? 16'h8809 : PAUSE_ETHERTYPE;
      op = rnd() % 3 == 0 ? OPCODE_GLOBAL : (rnd() % 4 == 0 ? 16'h0102 : OPCODE_PRIO);
      frame(da, 48'({rnd(), rnd()}), et, op, 16'(rnd()), rnd() % 8 == 0, m);
    end
    tally_and_finish();
  end
endmodule

/* logic/rx_pause_parser.sv */
// byte-stream header capture for pause frames
// assumes bytes arrive synchronous to clk, start marked by sop, end by eop
`timescale 1ns/1ps
module rx_pause_parser (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // frame stream
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic rx_err,
  // captured header
  output rx_pause_pkg::frame_t frame,
  output logic frame_done
);
  import rx_pause_pkg::*;

  typedef struct packed {
    parse_state_t st;
    logic [5:0] cnt;
    frame_t frm;
    logic done;
  } parse_ff_t;

  parse_ff_t st_ff;
  parse_ff_t nxt_st;

  function automatic hdr_t shift_in(hdr_t h, logic [7:0] b);
    return {h[8*HDR_BYTES-9:0], b};
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.st)
      PS_IDLE: begin
        if (rx_valid && rx_sop) begin
          nxt_st.frm.hdr = shift_in('0, rx_data);
          nxt_st.cnt = 6'h01;
          nxt_st.st = PS_RECV;
        end
      end
      PS_RECV: begin
        // a stray sop restarts capture rather than merging two frames
        if (rx_valid && rx_sop) begin
          nxt_st.frm.hdr = shift_in('0, rx_data);
          nxt_st.cnt = 6'h01;
        end else if (rx_valid && st_ff.cnt < HDR_CNT) begin
          nxt_st.frm.hdr = shift_in(st_ff.frm.hdr, rx_data);
          nxt_st.cnt = st_ff.cnt + 6'h01;
        end
      end
      default: nxt_st.st = PS_IDLE;
    endcase
    if (rx_valid && rx_eop && nxt_st.st == PS_RECV) begin
      nxt_st.done = 1'b1;
      nxt_st.frm.good = !rx_err && nxt_st.cnt == HDR_CNT;
      nxt_st.st = PS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{st: PS_IDLE, cnt: 6'h00, frm: '0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign frame = st_ff.frm;
  assign frame_done = st_ff.done;
endmodule

/* logic/rx_pause_pkg.sv */
// constants, field layouts and types for the receive pause interface
// assumes a single 200 MHz receive clock and a byte-wide frame stream
package rx_pause_pkg;
  localparam int NUM_SLOTS = 9;
  localparam int NUM_PRIO = 8;
  localparam int GLOBAL_SLOT = 8;
  localparam int QUANTA_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STATUS_W = 4;
  localparam int CNT_W = 16;
  localparam real CLK_PERIOD_NS = 5.0;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRIO_EN = 8'h04;
  localparam logic [7:0] ADDR_STN_LO = 8'h08;
  localparam logic [7:0] ADDR_STN_HI = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_EN = 8'h14;
  localparam logic [7:0] ADDR_INT_CLR = 8'h18;
  localparam logic [7:0] ADDR_REQ_STATE = 8'h1c;
  localparam logic [7:0] ADDR_CNT_PRIO = 8'h20;
  localparam logic [7:0] ADDR_CNT_GLOB = 8'h24;
  localparam logic [7:0] ADDR_CNT_REJ = 8'h28;

  // control register bit positions
  localparam int CTRL_PPE_BIT = 0;
  localparam int CTRL_MCAST_BIT = 1;
  localparam int CTRL_UCAST_BIT = 2;
  localparam int CTRL_SA_BIT = 3;
  localparam int CTRL_ETYPE_BIT = 4;
  localparam int CTRL_OPCODE_BIT = 5;
  localparam int CTRL_GLOBAL_BIT = 8;

  // status, enable and clear bit positions
  localparam int ST_PRIO_BIT = 0;
  localparam int ST_GLOB_BIT = 1;
  localparam int ST_REJ_BIT = 2;
  localparam int ST_OVR_BIT = 3;

  // frame layout, byte offsets from the first destination byte
  localparam int HDR_BYTES = 34;
  localparam logic [5:0] HDR_CNT = 6'h22;
  localparam int OFS_DA = 0;
  localparam int OFS_SA = 6;
  localparam int OFS_ETYPE = 12;
  localparam int OFS_OPCODE = 14;
  localparam int OFS_CEV = 16;
  localparam int OFS_GLOBAL_TIME = 16;
  localparam int OFS_TIME = 18;
  localparam int ADDR_GROUP_BIT = 40;

  localparam logic [47:0] PAUSE_MCAST_DA = 48'h0180_c200_0001;
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [15:0] OPCODE_PRIO = 16'h0101;
  localparam logic [15:0] OPCODE_GLOBAL = 16'h0001;

  // reset values
  localparam logic [8:0] PRIO_EN_RESET = 9'h1ff;
  localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;

  typedef logic [8*HDR_BYTES-1:0] hdr_t;
  typedef logic [NUM_SLOTS-1:0][QUANTA_W-1:0] quanta_arr_t;

  typedef struct packed {
    hdr_t hdr;
    logic good;
  } frame_t;

  typedef struct packed {
    logic global_pause_enable;
    logic rx_prio_pause_opcode_check;
    logic rx_prio_pause_ethertype_check;
    logic rx_prio_pause_srcaddr_check;
    logic rx_prio_pause_ucast_check;
    logic rx_prio_pause_mcast_check;
    logic rx_prio_pause_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 7'h71;

  typedef enum logic [1:0] {PS_IDLE = 2'h1, PS_RECV = 2'h2} parse_state_t;

  function automatic logic [15:0] hdr_f16(hdr_t h, int ofs);
    return h[8*(HDR_BYTES-2-ofs) +: 16];
  endfunction

  function automatic logic [47:0] hdr_f48(hdr_t h, int ofs);
    return h[8*(HDR_BYTES-6-ofs) +: 48];
  endfunction
endpackage

/* logic/rx_pause_slot.sv */
// one request, valid and quanta slot of the pause user interface
// assumes the user acknowledges in the same clock domain
`timescale 1ns/1ps
module rx_pause_slot (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // load from frame checker
  input wire logic load,
  input wire logic [15:0] load_quanta,
  // user side
  input wire logic ack,
  output logic req,
  output logic valid,
  output logic [15:0] quanta
);
  import rx_pause_pkg::*;

  typedef struct packed {
    logic req;
    logic valid;
    logic [15:0] quanta;
  } slot_ff_t;

  slot_ff_t st_ff;
  slot_ff_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.valid = load;
    if (load) begin
      nxt_st.quanta = load_quanta;
    end
    // a new frame in the acknowledge cycle keeps the request up
    nxt_st.req = load | (st_ff.req & ~ack);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req = st_ff.req;
  assign valid = st_ff.valid;
  assign quanta = st_ff.quanta;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_loaded;
    req && valid;
  endsequence

  property p_req_on_load;
    load |=> s_loaded ##0 (quanta == $past(load_quanta));
  endproperty
  a_req_on_load: assert property (p_req_on_load) else $error("load did not raise req, valid and quanta");

  property p_req_hold;
    req && !ack |=> req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped without acknowledge");

  property p_req_drop;
    $fell(req) |-> $past(ack) && !$past(load);
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request fell without a prior acknowledge");

  property p_valid_pulse;
    valid |-> $past(load) ##1 (valid == $past(load));
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid not tied to a load");
endmodule

/* logic/rx_priority_pause_interface.sv */
// receive pause frame checker with per-priority user handshake and registers
// assumes one clock, a synchronous byte stream and a never-waiting register master
`timescale 1ns/1ps
module rx_priority_pause_interface (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [rx_pause_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rx_pause_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [rx_pause_pkg::DATA_W-1:0] RDATA,
  // receive frame stream
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_SOP,
  input wire logic RX_EOP,
  input wire logic RX_ERR,
  // pause user interface
  output logic [rx_pause_pkg::NUM_SLOTS-1:0] RX_PAUSE_REQ,
  output logic [rx_pause_pkg::NUM_SLOTS-1:0] RX_PAUSE_VALID,
  output rx_pause_pkg::quanta_arr_t RX_PAUSE_QUANTA,
  input wire logic [rx_pause_pkg::NUM_SLOTS-1:0] RX_PAUSE_ACKNOWLEDGE,
  // interrupt
  output logic IRQ
);
  import rx_pause_pkg::*;

  typedef struct packed {
    ctrl_t ctrl;
    logic [NUM_SLOTS-1:0] rx_pause_priority_enable;
    logic [47:0] station;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] int_en;
    logic [CNT_W-1:0] cnt_prio;
    logic [CNT_W-1:0] cnt_glob;
    logic [CNT_W-1:0] cnt_rej;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } top_ff_t;

  top_ff_t st_ff;
  top_ff_t nxt_st;

  frame_t frame;
  logic frame_done;
  logic [47:0] da;
  logic [47:0] sa;
  logic [15:0] etype;
  logic [15:0] opcode;
  logic [15:0] cev_word;
  logic [7:0] cev;
  logic da_mcast;
  logic da_ucast;
  logic da_ok;
  logic sa_ok;
  logic et_ok;
  logic op_ok;
  logic is_global;
  logic prio_accept;
  logic glob_accept;
  logic rejected;
  logic overrun;
  logic [NUM_SLOTS-1:0] load_vec;
  quanta_arr_t load_q;
  logic [15:0] glob_q;
  logic [STATUS_W-1:0] events;
  logic [DATA_W-1:0] rd_word;
  logic wr_cnt_prio;
  logic wr_cnt_glob;
  logic wr_cnt_rej;

  // saturating so software never sees a wrapped count
  function automatic logic [CNT_W-1:0] cnt_next(logic [CNT_W-1:0] c, logic inc, logic clr);
    logic [CNT_W-1:0] base;
    base = clr ? 16'h0000 : c;
    return (inc && base != 16'hffff) ? base + 16'h0001 : base;
  endfunction

  rx_pause_parser u_parser (
    .clk(CLK),
    .reset_n(RESET_N),
    .rx_data(RX_DATA),
    .rx_valid(RX_VALID),
    .rx_sop(RX_SOP),
    .rx_eop(RX_EOP),
    .rx_err(RX_ERR),
    .frame(frame),
    .frame_done(frame_done)
  );

  // frame qualification
  always_comb begin
    da = hdr_f48(frame.hdr, OFS_DA);
    sa = hdr_f48(frame.hdr, OFS_SA);
    etype = hdr_f16(frame.hdr, OFS_ETYPE);
    opcode = hdr_f16(frame.hdr, OFS_OPCODE);
    cev_word = hdr_f16(frame.hdr, OFS_CEV);
    cev = cev_word[7:0];
    glob_q = hdr_f16(frame.hdr, OFS_GLOBAL_TIME);
    da_mcast = da == PAUSE_MCAST_DA;
    da_ucast = da == st_ff.station;
    da_ok = (!st_ff.ctrl.rx_prio_pause_mcast_check && !st_ff.ctrl.rx_prio_pause_ucast_check)
      || (st_ff.ctrl.rx_prio_pause_mcast_check && da_mcast)
      || (st_ff.ctrl.rx_prio_pause_ucast_check && da_ucast);
    sa_ok = !st_ff.ctrl.rx_prio_pause_srcaddr_check || !sa[ADDR_GROUP_BIT];
    et_ok = !st_ff.ctrl.rx_prio_pause_ethertype_check || etype == PAUSE_ETHERTYPE;
    op_ok = !st_ff.ctrl.rx_prio_pause_opcode_check || opcode == OPCODE_PRIO;
    is_global = etype == PAUSE_ETHERTYPE && opcode == OPCODE_GLOBAL;
    glob_accept = frame_done && frame.good && st_ff.ctrl.global_pause_enable && is_global
      && (da_mcast || da_ucast);
    prio_accept = frame_done && frame.good && st_ff.ctrl.rx_prio_pause_enable && !is_global
      && da_ok && sa_ok && et_ok && op_ok;
    rejected = frame_done && etype == PAUSE_ETHERTYPE && !prio_accept && !glob_accept;
    for (int i = 0; i < NUM_PRIO; i++) begin
      load_q[i] = hdr_f16(frame.hdr, OFS_TIME + 2 * i);
    end
    load_q[GLOBAL_SLOT] = glob_q;
    // the enable masks only what the user sees; status and counters still record
    load_vec = {glob_accept, cev & {NUM_PRIO{prio_accept}}} & st_ff.rx_pause_priority_enable;
    overrun = |(load_vec & RX_PAUSE_REQ & ~RX_PAUSE_ACKNOWLEDGE);
    events = '0;
    events[ST_PRIO_BIT] = prio_accept;
    events[ST_GLOB_BIT] = glob_accept;
    events[ST_REJ_BIT] = rejected;
    events[ST_OVR_BIT] = overrun;
  end

  generate
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      rx_pause_slot u_slot (
        .clk(CLK),
        .reset_n(RESET_N),
        .load(load_vec[g]),
        .load_quanta(load_q[g]),
        .ack(RX_PAUSE_ACKNOWLEDGE[g]),
        .req(RX_PAUSE_REQ[g]),
        .valid(RX_PAUSE_VALID[g]),
        .quanta(RX_PAUSE_QUANTA[g])
      );
    end
  endgenerate

  // register read mux
  always_comb begin
    rd_word = '0;
    case (ADDR)
      ADDR_CTRL: begin
        rd_word[CTRL_PPE_BIT] = st_ff.ctrl.rx_prio_pause_enable;
        rd_word[CTRL_MCAST_BIT] = st_ff.ctrl.rx_prio_pause_mcast_check;
        rd_word[CTRL_UCAST_BIT] = st_ff.ctrl.rx_prio_pause_ucast_check;
        rd_word[CTRL_SA_BIT] = st_ff.ctrl.rx_prio_pause_srcaddr_check;
        rd_word[CTRL_ETYPE_BIT] = st_ff.ctrl.rx_prio_pause_ethertype_check;
        rd_word[CTRL_OPCODE_BIT] = st_ff.ctrl.rx_prio_pause_opcode_check;
        rd_word[CTRL_GLOBAL_BIT] = st_ff.ctrl.global_pause_enable;
      end
      ADDR_PRIO_EN: rd_word[NUM_SLOTS-1:0] = st_ff.rx_pause_priority_enable;
      ADDR_STN_LO: rd_word = st_ff.station[31:0];
      ADDR_STN_HI: rd_word[15:0] = st_ff.station[47:32];
      ADDR_STATUS: rd_word[STATUS_W-1:0] = st_ff.status;
      ADDR_INT_EN: rd_word[STATUS_W-1:0] = st_ff.int_en;
      ADDR_REQ_STATE: rd_word[NUM_SLOTS-1:0] = RX_PAUSE_REQ;
      ADDR_CNT_PRIO: rd_word[CNT_W-1:0] = st_ff.cnt_prio;
      ADDR_CNT_GLOB: rd_word[CNT_W-1:0] = st_ff.cnt_glob;
      ADDR_CNT_REJ: rd_word[CNT_W-1:0] = st_ff.cnt_rej;
      default: rd_word = '0;
    endcase
  end

  // register writes, status and interrupt
  always_comb begin
    nxt_st = st_ff;
    wr_cnt_prio = WR && ADDR == ADDR_CNT_PRIO;
    wr_cnt_glob = WR && ADDR == ADDR_CNT_GLOB;
    wr_cnt_rej = WR && ADDR == ADDR_CNT_REJ;
    // clear first, then set, so an event in the clear cycle survives
    nxt_st.status = st_ff.status;
    if (WR) begin
      case (ADDR)
        ADDR_CTRL: begin
          nxt_st.ctrl.rx_prio_pause_enable = WDATA[CTRL_PPE_BIT];
          nxt_st.ctrl.rx_prio_pause_mcast_check = WDATA[CTRL_MCAST_BIT];
          nxt_st.ctrl.rx_prio_pause_ucast_check = WDATA[CTRL_UCAST_BIT];
          nxt_st.ctrl.rx_prio_pause_srcaddr_check = WDATA[CTRL_SA_BIT];
          nxt_st.ctrl.rx_prio_pause_ethertype_check = WDATA[CTRL_ETYPE_BIT];
          nxt_st.ctrl.rx_prio_pause_opcode_check = WDATA[CTRL_OPCODE_BIT];
          nxt_st.ctrl.global_pause_enable = WDATA[CTRL_GLOBAL_BIT];
        end
        ADDR_PRIO_EN: nxt_st.rx_pause_priority_enable = WDATA[NUM_SLOTS-1:0];
        ADDR_STN_LO: nxt_st.station[31:0] = WDATA;
        ADDR_STN_HI: nxt_st.station[47:32] = WDATA[15:0];
        ADDR_INT_EN: nxt_st.int_en = WDATA[STATUS_W-1:0];
        ADDR_INT_CLR: nxt_st.status = st_ff.status & ~WDATA[STATUS_W-1:0];
        default: nxt_st.status = st_ff.status;
      endcase
    end
    nxt_st.status = nxt_st.status | events;
    nxt_st.cnt_prio = cnt_next(st_ff.cnt_prio, prio_accept, wr_cnt_prio);
    nxt_st.cnt_glob = cnt_next(st_ff.cnt_glob, glob_accept, wr_cnt_glob);
    nxt_st.cnt_rej = cnt_next(st_ff.cnt_rej, rejected, wr_cnt_rej);
    nxt_st.rdata = RD ? rd_word : '0;
    nxt_st.irq = |(nxt_st.status & nxt_st.int_en);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '{ctrl: CTRL_RESET, rx_pause_priority_enable: PRIO_EN_RESET, station: STATION_RESET,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA = st_ff.rdata;
  assign IRQ = st_ff.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_no_prio_out;
    RX_PAUSE_VALID[NUM_PRIO-1:0] == 8'h00;
  endsequence

  property p_prio_off;
    frame_done && !st_ff.ctrl.rx_prio_pause_enable |=> s_no_prio_out;
  endproperty
  a_prio_off: assert property (p_prio_off) else $error("priority output while disabled");

  property p_mcast;
    frame_done && st_ff.ctrl.rx_prio_pause_mcast_check && !st_ff.ctrl.rx_prio_pause_ucast_check
      && !da_mcast |=> s_no_prio_out;
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast check let a frame through");

  property p_ucast;
    frame_done && st_ff.ctrl.rx_prio_pause_ucast_check && !st_ff.ctrl.rx_prio_pause_mcast_check
      && !da_ucast |=> s_no_prio_out;
  endproperty
  a_ucast: assert property (p_ucast) else $error("unicast check let a frame through");

  property p_srcaddr;
    frame_done && st_ff.ctrl.rx_prio_pause_srcaddr_check && sa[ADDR_GROUP_BIT] |=> s_no_prio_out;
  endproperty
  a_srcaddr: assert property (p_srcaddr) else $error("group source address accepted");

  property p_ethertype;
    frame_done && st_ff.ctrl.rx_prio_pause_ethertype_check && etype != PAUSE_ETHERTYPE |=> s_no_prio_out;
  endproperty
  a_ethertype: assert property (p_ethertype) else $error("wrong ethertype accepted");

  property p_opcode;
    frame_done && st_ff.ctrl.rx_prio_pause_opcode_check && opcode != OPCODE_PRIO |=> s_no_prio_out;
  endproperty
  a_opcode: assert property (p_opcode) else $error("wrong opcode accepted");

  property p_prio_mask;
    prio_accept |=> RX_PAUSE_VALID[NUM_PRIO-1:0] == $past(cev & st_ff.rx_pause_priority_enable[NUM_PRIO-1:0]);
  endproperty
  a_prio_mask: assert property (p_prio_mask) else $error("priority valid not class vector and enable");

  property p_global;
    glob_accept && st_ff.rx_pause_priority_enable[GLOBAL_SLOT] |=> RX_PAUSE_VALID[GLOBAL_SLOT]
      && RX_PAUSE_QUANTA[GLOBAL_SLOT] == $past(glob_q) && RX_PAUSE_VALID[NUM_PRIO-1:0] == 8'h00;
  endproperty
  a_global: assert property (p_global) else $error("global pause not on slot eight");

  property p_global_req;
    glob_accept && st_ff.rx_pause_priority_enable[GLOBAL_SLOT] |=> RX_PAUSE_REQ[GLOBAL_SLOT];
  endproperty
  a_global_req: assert property (p_global_req) else $error("global pause raised no request");

  // status and counters see every accepted frame, whatever the slot enables say
  property p_prio_status;
    prio_accept |=> st_ff.status[ST_PRIO_BIT] && st_ff.cnt_prio != 16'h0000;
  endproperty
  a_prio_status: assert property (p_prio_status) else $error("accepted priority frame not recorded");

  property p_reject_status;
    frame_done && !frame.good && etype == PAUSE_ETHERTYPE |=> st_ff.status[ST_REJ_BIT];
  endproperty
  a_reject_status: assert property (p_reject_status) else $error("bad pause frame not flagged");

  property p_requeue;
    load_vec[GLOBAL_SLOT] && RX_PAUSE_REQ[GLOBAL_SLOT] && !RX_PAUSE_ACKNOWLEDGE[GLOBAL_SLOT]
      |=> RX_PAUSE_REQ[GLOBAL_SLOT] && st_ff.status[ST_OVR_BIT];
  endproperty
  a_requeue: assert property (p_requeue) else $error("pending request not requeued");

  property p_rdata_idle;
    !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule
